// *** verilog/flash_id_pkg.sv ***
// Constants for the identification and mode-switch command decoder.
// Assumes a 100 MHz system clock that oversamples the serial pins.
package flash_id_pkg;

    // Command opcodes
    localparam logic [7:0] OP_RELEASE      = 8'hab;
    localparam logic [7:0] OP_MFR_DEV      = 8'h90;
    localparam logic [7:0] OP_MFR_DEV_DUAL = 8'h92;
    localparam logic [7:0] OP_MFR_DEV_QUAD = 8'h94;
    localparam logic [7:0] OP_STD_ID       = 8'h9f;
    localparam logic [7:0] OP_QUAD_ON      = 8'h38;
    localparam logic [7:0] OP_QUAD_OFF     = 8'hff;
    localparam logic [7:0] OP_POWER_DOWN   = 8'hb9;

    // Frame field lengths in bits, quad dummy clock count and swap address
    localparam logic [5:0] OPCODE_BITS    = 6'h08;
    localparam int         ADDR_BITS      = 24;
    localparam int         MODE_BITS      = 8;
    localparam logic [5:0] ADDR_LEN       = 6'h18;
    localparam logic [5:0] ADDR_MODE_LEN  = 6'h20;
    localparam logic [5:0] ID_DUMMY_LEN   = 6'h18;
    localparam logic [2:0] QUAD_DUMMY_CLK = 3'h4;
    localparam logic [3:0] BYTE_BITS      = 4'h8;
    localparam logic [23:0] SWAP_ADDR     = 24'h000001;

    // Data lane counts
    localparam logic [2:0] LANE_1 = 3'h1;
    localparam logic [2:0] LANE_2 = 3'h2;
    localparam logic [2:0] LANE_4 = 3'h4;

    // Output enables per lane count (data out on line 1 when single)
    localparam logic [3:0] OE_SINGLE = 4'h2;
    localparam logic [3:0] OE_DUAL   = 4'h3;
    localparam logic [3:0] OE_QUAD   = 4'hf;

    // Standard identifier byte positions
    localparam logic [1:0] ID_IDX_MAKER = 2'h0;
    localparam logic [1:0] ID_IDX_MEM   = 2'h1;
    localparam logic [1:0] ID_IDX_CAP   = 2'h2;

    // Recovery times in ns and derived clock counts (least, rounded up)
    localparam int CLK_PERIOD_NS             = 10;
    localparam int RELEASE_RECOVERY_TIME_NS  = 3000;
    localparam int ID_READ_RECOVERY_TIME_NS  = 1800;
    localparam int REC_W                     = 10;
    localparam logic [REC_W-1:0] RELEASE_RECOVERY_CYC =
        REC_W'((RELEASE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [REC_W-1:0] ID_READ_RECOVERY_CYC =
        REC_W'((ID_READ_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Synchroniser bundle layout: chip select, clock, four data lines
    localparam int SYNC_W      = 6;
    localparam int SYNC_CS     = 0;
    localparam int SYNC_SCK    = 1;
    localparam int SYNC_IO_LSB = 2;
    localparam logic [SYNC_W-1:0] SYNC_RST = 6'h01;

    // Frame phases
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_OPCODE,
        PH_ADDR,
        PH_DUMMY,
        PH_DATA,
        PH_IGNORE
    } phase_t;

endpackage

// *** verilog/pin_sync_if.sv ***
// Bundle of raw pin levels and their synchronised copies.
// Assumes one producer of raw levels and one synchroniser stage.
`timescale 1ns/1ps
interface pin_sync_if;
    import flash_id_pkg::*;
    logic [SYNC_W-1:0] raw;   // Pin levels, foreign domain
    logic [SYNC_W-1:0] sync;  // Levels after two flip-flops
    modport stage (input raw, output sync);
    modport user  (output raw, input sync);
endinterface

// *** verilog/pin_sync.sv ***
// Two flip-flop synchroniser for the serial pins.
// Assumes raw levels arrive from outside the system clock domain.
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    // Pin bundle
    pin_sync_if.stage          pins
);
    import flash_id_pkg::*;

    logic [SYNC_W-1:0] meta;  // First stage, read only by second
    logic [SYNC_W-1:0] held;  // Second stage

    // Both stages take the idle level under reset
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta <= SYNC_RST;
            held <= SYNC_RST;
        end else begin
            meta <= pins.raw;
            held <= meta;
        end
    end

    assign pins.sync = held;

endmodule

// *** verilog/flash_id_cmd.sv ***
// Identification, power-down release and quad mode switch decoder.
// Assumes serial pins are asynchronous and the status bits are local.
`timescale 1ns/1ps

module flash_id_cmd
    import flash_id_pkg::*;
#(
    parameter logic [7:0] MAKER_BYTE       = 8'h5a,  // Arbitrary value
    parameter logic [7:0] DEVICE_BYTE      = 8'h3c,  // Arbitrary value
    parameter logic [7:0] MEMORY_TYPE_BYTE = 8'h42,  // Arbitrary value
    parameter logic [7:0] CAPACITY_BYTE    = 8'h18   // Arbitrary value
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Serial pins
    input  wire logic       cs_n_i,
    input  wire logic       sck_i,
    input  wire logic [3:0] io_i,
    output logic      [3:0] io_o,
    output logic      [3:0] io_oe_o,
    // Status logic
    input  wire logic       busy_i,
    input  wire logic       quad_io_enable_i,
    // Mode report
    output logic            quad_command_mode_o,
    output logic            deep_power_down_o,
    output logic            cmd_ready_o
);
    import flash_id_pkg::*;

    // Whole state of the decoder
    typedef struct packed {
        phase_t           phase;      // Frame phase
        logic             dpd;        // Deep power-down
        logic             quad_command_mode;        // Quad command mode
        logic [7:0]       op;         // Latched opcode
        logic             op_done;    // Opcode accepted
        logic             extra;      // Clocks after opcode
        logic [31:0]      in_sr;      // Input shift register
        logic [5:0]       bit_cnt;    // Bits in current phase
        logic [5:0]       len;        // Address phase length
        logic [2:0]       lanes;      // Active data lines
        logic [2:0]       dummy_left; // Dummy clocks left
        logic             swap;       // Device byte first
        logic [7:0]       out_sr;     // Output shift register
        logic [3:0]       out_left;   // Bits left in byte
        logic [1:0]       byte_idx;   // Next byte to send
        logic [REC_W-1:0] rec_cnt;    // Recovery countdown
        logic             ready;      // No recovery pending
        logic             sck_prev;   // Clock one cycle ago
        logic             cs_prev;    // Select one cycle ago
        logic [3:0]       io_out;     // Driven data levels
        logic [3:0]       io_oe;      // Driven data enables
    } state_t;

    // Serial mode, awake, deselected after reset
    localparam state_t STATE_RESET = '{
        phase:    PH_IDLE,
        cs_prev:  1'b1,
        ready:    1'b1,
        default:  '0
    };

    state_t s;       // Registered state
    state_t next_s;  // Next state

    logic        cs_n_s;    // Synchronised select
    logic        sck_s;     // Synchronised clock
    logic [3:0]  io_s;      // Synchronised data lines
    logic        sck_rise;  // Serial clock rising
    logic        sck_fall;  // Serial clock falling
    logic [31:0] in_shift;  // Input register after one shift
    logic [23:0] addr_in;   // Address from shifted input
    logic [7:0]  sel_byte;  // Byte to start sending
    logic [1:0]  idx_step;  // Index after that byte
    logic [7:0]  cur_byte;  // Byte being sent this edge

    pin_sync_if pins ();

    // Raw pins into the synchroniser
    assign pins.raw = {io_i, sck_i, cs_n_i};

    pin_sync u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pins      (pins)
    );

    // Synchronised copies
    assign cs_n_s = pins.sync[SYNC_CS];
    assign sck_s  = pins.sync[SYNC_SCK];
    assign io_s   = pins.sync[SYNC_IO_LSB +: 4];

    // Edges of the sampled serial clock
    assign sck_rise = sck_s & ~s.sck_prev;
    assign sck_fall = ~sck_s & s.sck_prev;

    // Shift in one, two or four lines per rising edge
    always_comb begin
        case (s.lanes)
            LANE_2: begin
                in_shift = {s.in_sr[29:0], io_s[1:0]};
            end
            LANE_4: begin
                in_shift = {s.in_sr[27:0], io_s};
            end
            default: begin
                in_shift = {s.in_sr[30:0], io_s[0]};
            end
        endcase
    end

    // Address sits ahead of the mode byte when one follows
    always_comb begin
        if (s.len == ADDR_MODE_LEN) begin
            addr_in = in_shift[ADDR_BITS+MODE_BITS-1 -: ADDR_BITS];
        end else begin
            addr_in = in_shift[ADDR_BITS-1:0];
        end
    end

    // Choose next identifier byte and the index after it
    always_comb begin
        case (s.op)
            OP_RELEASE: begin
                sel_byte = DEVICE_BYTE;
                idx_step = ID_IDX_MAKER;
            end
            OP_STD_ID: begin
                // Maker, memory type, capacity, then again
                if (s.byte_idx == ID_IDX_MEM) begin
                    sel_byte = MEMORY_TYPE_BYTE;
                    idx_step = ID_IDX_CAP;
                end else if (s.byte_idx == ID_IDX_CAP) begin
                    sel_byte = CAPACITY_BYTE;
                    idx_step = ID_IDX_MAKER;
                end else begin
                    sel_byte = MAKER_BYTE;
                    idx_step = ID_IDX_MEM;
                end
            end
            default: begin
                // Alternate maker and device, order set by address
                if (s.byte_idx[0] ^ s.swap) begin
                    sel_byte = DEVICE_BYTE;
                end else begin
                    sel_byte = MAKER_BYTE;
                end
                idx_step = {1'b0, ~s.byte_idx[0]};
            end
        endcase
    end

    // Fresh byte when the last one is used up
    assign cur_byte = (s.out_left == '0) ? sel_byte : s.out_sr;

    // Frame decoding and shifting, one step per system clock
    always_comb begin
        next_s          = s;
        next_s.sck_prev = sck_s;
        next_s.cs_prev  = cs_n_s;
        // Recovery countdown runs regardless of frames
        if (s.rec_cnt != '0) begin
            next_s.rec_cnt = s.rec_cnt - 1'b1;
        end
        if (cs_n_s) begin
            // Deselect ends the frame and applies its action
            if (!s.cs_prev && s.op_done) begin
                case (s.op)
                    OP_RELEASE: begin
                        next_s.dpd = 1'b0;
                        if (s.extra) begin
                            next_s.rec_cnt = ID_READ_RECOVERY_CYC;
                        end else begin
                            next_s.rec_cnt = RELEASE_RECOVERY_CYC;
                        end
                    end
                    OP_POWER_DOWN: begin
                        // Only at the byte boundary
                        if (!s.extra) begin
                            next_s.dpd = 1'b1;
                        end
                    end
                    OP_QUAD_ON: begin
                        // Write latch, suspend and wrap are not touched
                        if (!s.extra && quad_io_enable_i) begin
                            next_s.quad_command_mode = 1'b1;
                        end
                    end
                    OP_QUAD_OFF: begin
                        if (!s.extra) begin
                            next_s.quad_command_mode = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // Release the data lines while deselected
            next_s.phase   = PH_IDLE;
            next_s.io_out  = '0;
            next_s.io_oe   = '0;
            next_s.op_done = 1'b0;
            next_s.extra   = 1'b0;
        end else if (s.cs_prev) begin
            // New frame; refused while recovery is pending
            if (s.rec_cnt != '0) begin
                next_s.phase = PH_IGNORE;
            end else begin
                next_s.phase = PH_OPCODE;
            end
            next_s.bit_cnt  = '0;
            next_s.in_sr    = '0;
            next_s.out_left = '0;
            next_s.byte_idx = '0;
            next_s.swap     = 1'b0;
            next_s.lanes    = s.quad_command_mode ? LANE_4 : LANE_1;
        end else if (sck_rise) begin
            // Any clock after the opcode marks a longer frame
            if (s.op_done) begin
                next_s.extra = 1'b1;
            end
            case (s.phase)
                PH_OPCODE: begin
                    next_s.in_sr   = in_shift;
                    next_s.bit_cnt = s.bit_cnt + 6'(s.lanes);
                    if (next_s.bit_cnt == OPCODE_BITS) begin
                        next_s.op         = in_shift[7:0];
                        next_s.bit_cnt    = '0;
                        next_s.in_sr      = '0;
                        next_s.dummy_left = '0;
                        next_s.phase      = PH_IGNORE;
                        if (s.dpd && in_shift[7:0] != OP_RELEASE) begin
                            // Asleep: everything else is dropped
                            next_s.op_done = 1'b0;
                        end else if (in_shift[7:0] == OP_RELEASE && busy_i) begin
                            // Running cycle is left alone
                            next_s.op_done = 1'b0;
                        end else begin
                            next_s.op_done = 1'b1;
                            case (in_shift[7:0])
                                OP_RELEASE: begin
                                    // Quad mode only wakes, no identifier
                                    if (!s.quad_command_mode) begin
                                        next_s.phase = PH_ADDR;
                                        next_s.len   = ID_DUMMY_LEN;
                                        next_s.lanes = LANE_1;
                                    end
                                end
                                OP_MFR_DEV: begin
                                    next_s.phase = PH_ADDR;
                                    next_s.len   = ADDR_LEN;
                                end
                                OP_MFR_DEV_DUAL: begin
                                    next_s.op_done = ~s.quad_command_mode;
                                    if (!s.quad_command_mode) begin
                                        next_s.phase = PH_ADDR;
                                        next_s.len   = ADDR_MODE_LEN;
                                        next_s.lanes = LANE_2;
                                    end
                                end
                                OP_MFR_DEV_QUAD: begin
                                    next_s.op_done = ~s.quad_command_mode;
                                    if (!s.quad_command_mode) begin
                                        next_s.phase      = PH_ADDR;
                                        next_s.len        = ADDR_MODE_LEN;
                                        next_s.lanes      = LANE_4;
                                        next_s.dummy_left = QUAD_DUMMY_CLK;
                                    end
                                end
                                OP_STD_ID: begin
                                    next_s.phase = PH_DATA;
                                end
                                OP_QUAD_ON: begin
                                    // Only meaningful from serial mode
                                    next_s.op_done = ~s.quad_command_mode;
                                end
                                OP_QUAD_OFF: begin
                                    next_s.op_done = s.quad_command_mode;
                                end
                                OP_POWER_DOWN: begin
                                end
                                default: begin
                                    next_s.op_done = 1'b0;
                                end
                            endcase
                        end
                    end
                end
                PH_ADDR: begin
                    next_s.in_sr   = in_shift;
                    next_s.bit_cnt = s.bit_cnt + 6'(s.lanes);
                    if (next_s.bit_cnt == s.len) begin
                        next_s.swap = (addr_in == SWAP_ADDR);
                        if (s.dummy_left != '0) begin
                            next_s.phase = PH_DUMMY;
                        end else begin
                            next_s.phase = PH_DATA;
                        end
                    end
                end
                PH_DUMMY: begin
                    next_s.dummy_left = s.dummy_left - 1'b1;
                    if (next_s.dummy_left == '0) begin
                        next_s.phase = PH_DATA;
                    end
                end
                default: begin
                end
            endcase
        end else if (sck_fall && s.phase == PH_DATA) begin
            // Drive MSB first on the falling edge
            case (s.lanes)
                LANE_2: begin
                    next_s.io_out = {2'b00, cur_byte[7:6]};
                    next_s.io_oe  = OE_DUAL;
                end
                LANE_4: begin
                    next_s.io_out = cur_byte[7:4];
                    next_s.io_oe  = OE_QUAD;
                end
                default: begin
                    next_s.io_out = {2'b00, cur_byte[7], 1'b0};
                    next_s.io_oe  = OE_SINGLE;
                end
            endcase
            next_s.out_sr = cur_byte << s.lanes;
            if (s.out_left == '0) begin
                next_s.out_left = BYTE_BITS - 4'(s.lanes);
                next_s.byte_idx = idx_step;
            end else begin
                next_s.out_left = s.out_left - 4'(s.lanes);
            end
        end
        next_s.ready = (next_s.rec_cnt == '0);
    end

    // State register; reset lands in serial mode
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign io_o                = s.io_out;
    assign io_oe_o             = s.io_oe;
    assign quad_command_mode_o = s.quad_command_mode;
    assign deep_power_down_o   = s.dpd;
    assign cmd_ready_o         = s.ready;

endmodule

// *** sim/flash_id_cmd_asserts.sv ***
// Concurrent checks on the identification command decoder ports.
// Assumes it is bound to flash_id_cmd and sees only that module's ports.
`timescale 1ns/1ps
module flash_id_cmd_asserts (
    // Clock, reset and pins
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic       cs_n_i,
    input wire logic       sck_i,
    input wire logic [3:0] io_i,
    input wire logic [3:0] io_o,
    input wire logic [3:0] io_oe_o,
    // Status and mode
    input wire logic       busy_i,
    input wire logic       quad_io_enable_i,
    input wire logic       quad_command_mode_o,
    input wire logic       deep_power_down_o,
    input wire logic       cmd_ready_o
);
    logic [3:0] cs_high_cnt;  // Cycles with select high
    logic [8:0] low_cnt;      // Cycles with recovery pending
    // Idle and recovery counters
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !cs_n_i) begin
            cs_high_cnt <= 4'h0;
        end else if (cs_high_cnt != 4'hf) begin
            cs_high_cnt <= cs_high_cnt + 4'h1;
        end
        low_cnt <= (sys_rst_i || cmd_ready_o) ? 9'h000 : low_cnt + 9'h001;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_oe_lane_set: assert property (io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf})
        else $error("output enable pattern illegal");
    a_idle_no_drive: assert property (cs_high_cnt >= 4'h8 |-> io_oe_o == 4'h0)
        else $error("pins driven while deselected");
    a_drive_in_frame: assert property ($rose(|io_oe_o) |-> !cs_n_i && cmd_ready_o)
        else $error("drive began outside a frame");
    a_quad_lanes: assert property (quad_command_mode_o && |io_oe_o |-> io_oe_o == 4'hf)
        else $error("quad mode answered on too few lanes");
    a_mode_at_end: assert property ($changed(quad_command_mode_o) |->
        cs_n_i && $past(cs_n_i))
        else $error("mode changed inside a frame");
    a_quad_needs_qe: assert property ($rose(quad_command_mode_o) |-> quad_io_enable_i)
        else $error("quad mode entered without enable");
    a_wake_not_busy: assert property ($fell(deep_power_down_o) |-> !busy_i)
        else $error("woke while busy");
    a_pd_at_end: assert property ($changed(deep_power_down_o) |-> cs_n_i)
        else $error("power-down changed inside a frame");
    a_rec_length: assert property ($rose(cmd_ready_o) |->
        low_cnt inside {[9'd175:9'd185], [9'd295:9'd305]})
        else $error("recovery length wrong");
    a_rec_bound: assert property (!cmd_ready_o |-> low_cnt < 9'd320)
        else $error("recovery never ends");
    c_quad_on: cover property ($rose(quad_command_mode_o));
    c_wake: cover property ($fell(deep_power_down_o));
    c_quad_out: cover property (io_oe_o == 4'hf);
endmodule
bind flash_id_cmd flash_id_cmd_asserts chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cs_n_i(cs_n_i), .sck_i(sck_i), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o),
    .busy_i(busy_i), .quad_io_enable_i(quad_io_enable_i),
    .quad_command_mode_o(quad_command_mode_o), .deep_power_down_o(deep_power_down_o),
    .cmd_ready_o(cmd_ready_o));

// *** sim/flash_host_model.sv ***
// Host controller model: drives select, serial clock and data lines.
// Assumes a 100 MHz clock; the serial clock has an 80 ns period in frames.
`timescale 1ns/1ps
module flash_host_model (
    // Clock
    input  wire logic       clk_i,
    // Pins toward the device
    output logic            cs_n_o,
    output logic            sck_o,
    output logic      [3:0] io_o,
    input  wire logic [3:0] dev_io_i,
    input  wire logic [3:0] dev_oe_i
);
    logic [3:0] host_v = 4'h0;  // Host line levels
    logic [3:0] seen   = 4'h0;  // Enables seen this frame
    initial cs_n_o = 1'b1;
    initial sck_o  = 1'b0;      // Clock idles low between frames
    // Resolved line level from both parties
    assign io_o = (dev_oe_i & dev_io_i) | (~dev_oe_i & host_v);
    // Half a serial clock period
    task automatic half();
        repeat (4) @(posedge clk_i);
    endtask
    // Open a frame
    task automatic start();
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        seen = 4'h0;
        half();
    endtask
    // Send n bits MSB first over l lanes, sampled on rising edges
    task automatic shift(input logic [31:0] d, input int n, input int l);
        for (int i = 0; i < n / l; i++) begin
            sck_o  <= 1'b0;
            host_v <= 4'(d[31:28] >> (4 - l));
            d = d << l;
            half();
            sck_o <= 1'b1;
            half();
        end
    endtask
    // Collect n bits over l lanes, sampled three clocks after each rising edge
    task automatic grab(input int n, input int l, output logic [47:0] q);
        q = '0;
        for (int i = 0; i < n / l; i++) begin
            sck_o  <= 1'b0;
            host_v <= ~host_v;  // Released lines keep changing
            half();
            sck_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            #1;
            seen = seen | dev_oe_i;
            q = (q << l) | 48'((l == 1) ? {3'h0, io_o[1]} : (io_o & 4'((1 << l) - 1)));
            @(posedge clk_i);
        end
    endtask
    // Close the frame and hold select high a while
    task automatic stop();
        sck_o <= 1'b0;
        half();
        cs_n_o <= 1'b1;
        half();
        half();
    endtask
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the identification and mode switch decoder.
// Assumes the host model drives all pins; status bits come from here.
`timescale 1ns/1ps
module testbench;
    import flash_id_pkg::*;
    localparam logic [7:0] MK = 8'h5a;  // Arbitrary maker value
    localparam logic [7:0] DV = 8'h3c;  // Arbitrary device value
    localparam logic [7:0] MT = 8'h42;  // Arbitrary type value
    localparam logic [7:0] CP = 8'h18;  // Arbitrary capacity value
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        busy_i = 1'b0;
    logic        qe = 1'b0;
    logic        cs_n, sck;
    logic [3:0]  io_w, io_o, io_oe_o;
    logic        quad_command_mode_o, deep_power_down_o, cmd_ready_o;
    logic [47:0] got;
    int          fail_count = 0;
    int          checks_done = 0;
    always #5 clk_i = ~clk_i;
    flash_host_model host_u (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .io_o(io_w),
        .dev_io_i(io_o), .dev_oe_i(io_oe_o));
    flash_id_cmd #(.MAKER_BYTE(MK), .DEVICE_BYTE(DV), .MEMORY_TYPE_BYTE(MT),
        .CAPACITY_BYTE(CP)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n),
        .sck_i(sck), .io_i(io_w), .io_o(io_o), .io_oe_o(io_oe_o), .busy_i(busy_i),
        .quad_io_enable_i(qe), .quad_command_mode_o(quad_command_mode_o),
        .deep_power_down_o(deep_power_down_o), .cmd_ready_o(cmd_ready_o));
    // Report and end the run
    task automatic summarize();
        $display("mismatches %0d, checks %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Compare one value
    task automatic chk(input logic [47:0] g, input logic [47:0] e, input string m);
        #1;
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask
    // One command frame: opcode, address, dummy clocks, read back
    task automatic frame(input logic [7:0] op, input int ol, input logic [31:0] a,
                         input int an, input int al, input int dm, input int rn, input int rl);
        for (int i = 0; i < 2000 && cmd_ready_o !== 1'b1; i++) @(posedge clk_i);
        if (cmd_ready_o !== 1'b1) begin
            chk(48'(cmd_ready_o), 48'h1, "ready wait");
            summarize();
        end
        host_u.start();
        host_u.shift({op, 24'h0}, 8, ol);
        if (an > 0) host_u.shift(a, an, al);
        if (dm > 0) host_u.shift(32'h0, dm, 1);
        got = '0;
        if (rn > 0) host_u.grab(rn, rl, got);
        host_u.stop();
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        chk(48'({io_oe_o, quad_command_mode_o, deep_power_down_o, cmd_ready_o}),
            48'h1, "reset");
        frame(OP_STD_ID, 1, 32'h0, 0, 1, 0, 48, 1);
        chk(got, {MK, MT, CP, MK, MT, CP}, "std id");
        chk(48'(host_u.seen), 48'h2, "std id lanes");
        frame(OP_MFR_DEV, 1, 32'h0, 24, 1, 0, 32, 1);
        chk(got, 48'({MK, DV, MK, DV}), "maker first");
        frame(OP_MFR_DEV, 1, 32'h100, 24, 1, 0, 32, 1);
        chk(got, 48'({DV, MK, DV, MK}), "device first");
        frame(OP_MFR_DEV_DUAL, 1, 32'h100, 32, 2, 0, 16, 2);
        chk(48'({got[15:0], host_u.seen}), 48'({DV, MK, 4'h3}), "dual id");
        frame(OP_MFR_DEV_QUAD, 1, 32'h0, 32, 4, 4, 16, 4);
        chk(48'({got[15:0], host_u.seen}), 48'({MK, DV, 4'hf}), "quad id");
        frame(OP_POWER_DOWN, 1, 32'h0, 0, 1, 0, 0, 1);
        chk(48'(deep_power_down_o), 48'h1, "power-down");
        frame(OP_STD_ID, 1, 32'h0, 0, 1, 0, 8, 1);
        chk(48'({host_u.seen, deep_power_down_o}), 48'h1, "ignored in power-down");
        @(posedge clk_i) busy_i <= 1'b1;
        frame(OP_RELEASE, 1, 32'h0, 0, 1, 0, 0, 1);
        chk(48'(deep_power_down_o), 48'h1, "release while busy");
        @(posedge clk_i) busy_i <= 1'b0;
        frame(OP_RELEASE, 1, 32'h0, 0, 1, 0, 0, 1);
        chk(48'({deep_power_down_o, cmd_ready_o}), 48'h0, "release");
        frame(OP_POWER_DOWN, 1, 32'h0, 0, 1, 0, 0, 1);
        frame(OP_RELEASE, 1, 32'h0, 0, 1, 24, 16, 1);
        chk(48'({got[15:0], deep_power_down_o}), 48'({DV, DV, 1'b0}), "release id");
        frame(OP_QUAD_ON, 1, 32'h0, 0, 1, 0, 0, 1);
        chk(48'(quad_command_mode_o), 48'h0, "quad refused");
        @(posedge clk_i) qe <= 1'b1;
        frame(OP_QUAD_ON, 1, 32'h0, 0, 1, 0, 0, 1);
        chk(48'(quad_command_mode_o), 48'h1, "quad entered");
        frame(OP_STD_ID, 4, 32'h0, 0, 1, 0, 24, 4);
        chk(48'({got[23:0], host_u.seen}), 48'({MK, MT, CP, 4'hf}), "quad std id");
        frame(OP_RELEASE, 4, 32'h0, 0, 1, 0, 8, 4);
        chk(48'(host_u.seen), 48'h0, "no id in quad");
        frame(OP_QUAD_OFF, 4, 32'h0, 0, 1, 0, 0, 1);
        chk(48'(quad_command_mode_o), 48'h0, "quad left");
        summarize();
    end
endmodule
